// File: fhbt_fifo.sv
// fhbt_fifo: synchronous valid/ready fifo with occupancy output
// assumes one clock and a synchronised active-low reset
`timescale 1ns/10ps
module fhbt_fifo
    import fhbt_pkg::*;
#(
    parameter int unsigned WIDTH = FHBT_WIDTH,
    parameter int unsigned DEPTH = FHBT_DEPTH,
    parameter int unsigned AW    = $clog2(DEPTH)
)
(
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic      [AW:0]      o_level
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      lvl_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (lvl_q != (AW+1)'(DEPTH));
    assign o_out_valid = (lvl_q != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_q];
    assign o_level     = lvl_q;

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            lvl_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            lvl_q <= lvl_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : fhbt_fifo

// File: fhbt_host_model.sv
// fhbt_host_model: behavioural host bus master facing fhbt_top
// assumes grant and data move only just after the rising edge
`timescale 1ns/10ps
module fhbt_host_model
    import fhbt_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_req,
    input  wire logic                  i_write,
    input  wire logic [3:0]            i_lat,
    input  wire logic                  i_ready,
    input  wire logic                  i_valid,
    input  wire logic [FHBT_WIDTH-1:0] i_data,
    output logic                       o_gnt,
    output logic                       o_valid,
    output logic      [FHBT_WIDTH-1:0] o_data,
    output logic      [15:0]           o_beats,
    output logic      [15:0]           o_gaps,
    output logic      [FHBT_WIDTH-1:0] o_last
);
    logic [3:0]            wait_q;
    logic [FHBT_WIDTH-1:0] word_q;
    logic                  beat;
    assign o_valid = o_gnt && i_write;
    // idle bus shows the inverse so a stale word never passes as fresh
    assign o_data  = o_valid ? word_q : ~word_q;
    assign beat    = o_gnt && (i_write ? i_ready : i_valid);
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wait_q  <= 4'h0;
            o_gnt   <= 1'b0;
            o_beats <= 16'h0000;
            o_gaps  <= 16'h0000;
            o_last  <= 32'h0000_0000;
            word_q  <= 32'h1000_0000;
        end
        else
        begin
            wait_q <= (i_req && !o_gnt) ? wait_q + 4'h1 : 4'h0;
            o_gnt  <= i_req && (o_gnt || wait_q >= i_lat);
            // granted cycles without a word break full-rate bursts
            o_gaps <= o_gaps +
                      ((o_gnt && i_req && !beat) ? 16'h0001 : 16'h0000);
            if (beat)
            begin
                o_beats <= o_beats + 16'h0001;
                word_q  <= i_write ? word_q + 32'h0000_0001 : word_q;
                o_last  <= i_write ? o_last : i_data;
            end
        end
    end
endmodule : fhbt_host_model

// File: fhbt_pkg.sv
// fhbt_pkg: constants and types for the host burst threshold block
// assumes a single 250 MHz clock domain
package fhbt_pkg;

    // ------------------------------------------------------------------
    // fifo geometry and count width
    // ------------------------------------------------------------------
    localparam int unsigned FHBT_WIDTH   = 32;
    localparam int unsigned FHBT_DEPTH   = 16;
    localparam int unsigned FHBT_LVL_W   = 5;
    localparam int unsigned FHBT_CNT_W   = 24;

    // ------------------------------------------------------------------
    // threshold selector layout inside the host bus status byte
    // ------------------------------------------------------------------
    localparam int unsigned FHBT_SEL_LO_POS = 6;
    localparam int unsigned FHBT_SEL_HI_POS = 7;
    localparam logic [1:0]  FHBT_SEL_RST    = 2'h0;

    typedef enum logic [1:0] {
        FHBT_SEL_EAGER   = 2'h0,
        FHBT_SEL_HALF    = 2'h1,
        FHBT_SEL_QUARTER = 2'h2,
        FHBT_SEL_WHOLE   = 2'h3
    } fhbt_sel_type;

    typedef enum logic [1:0] {
        FHBT_ST_IDLE  = 2'b01,
        FHBT_ST_BURST = 2'b10
    } fhbt_state_type;

endpackage : fhbt_pkg

// File: fhbt_top.sv
// fhbt_top: host-side burst request logic around the data fifo
// assumes the host bus master grants and strobes on this clock
//
// Function
// R1: two-bit selector in status bits 6 and 7 picks request policy
// R2: mode 0,0 write: request whenever the fifo has free space
// R3: mode 0,0 read: drain as soon as the fifo holds data
// R4: mode 0,1 write: request at half full, fill until full
// R5: mode 0,1 read: request at half full, drain until empty
// R6: mode 1,0 write: request at three quarters empty, fill until full
// R7: mode 1,0 read: request at three quarters full, drain until empty
// R8: mode 1,1 write: request only once the fifo is empty
// R9: mode 1,1 read: request only once the fifo is full
// R10: granted bursts move one word every cycle at full rate
// R11: firmware programs default 1,1 or 1,0 per configuration
// R12: firmware may switch the 1,0 default to 0,0 after negotiation
// R13: thresholds come from depth; levels compared every cycle
// R14: burst ends at zero byte count; selector resets to 0,0
`timescale 1ns/10ps
module fhbt_top
    import fhbt_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [7:0]            i_host_bus_status_reg,
    input  wire logic                  i_sel_we,
    input  wire logic                  i_dir_write,
    input  wire logic                  i_cnt_load,
    input  wire logic [FHBT_CNT_W-1:0] i_cnt_value,
    output logic                       o_host_req,
    input  wire logic                  i_host_gnt,
    input  wire logic                  i_host_valid,
    input  wire logic [FHBT_WIDTH-1:0] i_host_data,
    output logic                       o_host_ready,
    output logic                       o_host_valid,
    output logic      [FHBT_WIDTH-1:0] o_host_data,
    input  wire logic                  i_scsi_valid,
    input  wire logic [FHBT_WIDTH-1:0] i_scsi_data,
    output logic                       o_scsi_ready,
    output logic                       o_scsi_valid,
    output logic      [FHBT_WIDTH-1:0] o_scsi_data,
    input  wire logic                  i_scsi_ready,
    output logic      [1:0]            o_fifo_level_sel,
    output logic                       o_cnt_zero
);

    localparam logic [FHBT_LVL_W-1:0] LVL_FULL = FHBT_LVL_W'(FHBT_DEPTH);
    localparam logic [FHBT_LVL_W-1:0] LVL_HALF = FHBT_LVL_W'(FHBT_DEPTH/2);
    localparam logic [FHBT_LVL_W-1:0] LVL_3Q   =
        FHBT_LVL_W'((FHBT_DEPTH*3)/4);
    localparam logic [FHBT_LVL_W-1:0] LVL_1Q   = FHBT_LVL_W'(FHBT_DEPTH/4);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        fhbt_state_type        st;
        fhbt_sel_type          sel;
        logic                  dir_wr;
        logic [FHBT_CNT_W-1:0] cnt;
    } fhbt_regs_type;

    fhbt_regs_type r_q;
    fhbt_regs_type r_d;

    logic [FHBT_LVL_W-1:0] level;
    logic                  start;
    logic                  done;
    logic                  stop;
    logic                  beat;
    logic                  burst;
    logic                  in_valid;
    logic                  in_ready;
    logic [FHBT_WIDTH-1:0] in_data;
    logic                  out_valid;
    logic                  out_ready;

    // one policy table used for both directions; dw picks which fill level compare applies
    function automatic logic start_ok(input fhbt_sel_type s,
                                      input logic dw,
                                      input logic [FHBT_LVL_W-1:0] lv);
        logic r;
        r = 1'b0;
        unique case (s)
            FHBT_SEL_EAGER:   r = dw ? (lv != LVL_FULL)  // [R2]
                                     : (lv != '0);       // [R3]
            FHBT_SEL_HALF:    r = dw ? (lv <= LVL_HALF)  // [R4]
                                     : (lv >= LVL_HALF); // [R5]
            FHBT_SEL_QUARTER: r = dw ? (lv <= LVL_1Q)    // [R6]
                                     : (lv >= LVL_3Q);   // [R7]
            FHBT_SEL_WHOLE:   r = dw ? (lv == '0)        // [R8]
                                     : (lv == LVL_FULL); // [R9]
        endcase
        return r;
    endfunction : start_ok

    assign burst = (r_q.st == FHBT_ST_BURST);
    assign start = start_ok(r_q.sel, r_q.dir_wr, level) &&
                   (r_q.cnt != '0); // [R13]
    assign beat  = burst && i_host_gnt && !stop &&
                   (r_q.dir_wr ? (i_host_valid && in_ready) : out_valid);
    // stop gates the host side of the data path; done also closes on the final beat, so
    // the last word still moves while the request drops in that cycle
    assign stop  = (r_q.cnt == '0) ||
                   (r_q.dir_wr ? (level == LVL_FULL) : (level == '0));
    assign done  = stop || ((r_q.cnt == FHBT_CNT_W'(1)) && beat); // [R14]

    always_comb
    begin
        r_d = r_q;
        if (i_sel_we)
        begin
            r_d.sel = fhbt_sel_type'(
                {i_host_bus_status_reg[FHBT_SEL_HI_POS],
                 i_host_bus_status_reg[FHBT_SEL_LO_POS]}); // [R1]
        end
        if (i_cnt_load)
        begin
            r_d.cnt    = i_cnt_value;
            r_d.dir_wr = i_dir_write;
        end
        else if (beat)
        begin
            r_d.cnt = r_q.cnt - FHBT_CNT_W'(1); // [R14]
        end
        unique case (r_q.st)
            FHBT_ST_IDLE:
            begin
                if (start && !i_cnt_load)
                begin
                    r_d.st = FHBT_ST_BURST;
                end
            end
            FHBT_ST_BURST:
            begin
                if (done || i_cnt_load)
                begin
                    r_d.st = FHBT_ST_IDLE;
                end
            end
            default:
            begin
                r_d.st = FHBT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q.st     <= FHBT_ST_IDLE;
            r_q.sel    <= fhbt_sel_type'(FHBT_SEL_RST); // [R14]
            r_q.dir_wr <= 1'b0;
            r_q.cnt    <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // data path: host fills in write, scsi fills in read
    // ------------------------------------------------------------------
    assign in_valid  = r_q.dir_wr ? (burst && i_host_gnt && i_host_valid &&
                                     !stop) : i_scsi_valid;
    assign in_data   = r_q.dir_wr ? i_host_data : i_scsi_data;
    assign out_ready = r_q.dir_wr ? i_scsi_ready :
                       (burst && i_host_gnt && !stop); // [R10]

    fhbt_fifo u_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (rst_n),
        .i_in_valid  (in_valid),
        .o_in_ready  (in_ready),
        .i_in_data   (in_data),
        .o_out_valid (out_valid),
        .i_out_ready (out_ready),
        .o_out_data  (o_scsi_data),
        .o_level     (level)
    );

    assign o_host_req       = burst && !done;              // [R10]
    assign o_host_ready     = r_q.dir_wr && burst && i_host_gnt && in_ready &&
                              !stop;
    assign o_host_valid     = !r_q.dir_wr && burst && i_host_gnt &&
                              out_valid && !stop;
    assign o_host_data      = o_scsi_data;
    assign o_scsi_ready     = !r_q.dir_wr && in_ready;
    assign o_scsi_valid     = r_q.dir_wr && out_valid;
    assign o_fifo_level_sel = r_q.sel;
    assign o_cnt_zero       = (r_q.cnt == '0);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_whole_wr;
        @(posedge i_clk) disable iff (!rst_n)
        (r_q.st == FHBT_ST_IDLE && r_q.sel == FHBT_SEL_WHOLE && r_q.dir_wr &&
         !i_cnt_load && level != '0) |=> (r_q.st == FHBT_ST_IDLE);
    endproperty
    a_whole_wr: assert property (p_whole_wr) // [R8]
        else $error("early write req");

    property p_whole_rd;
        @(posedge i_clk) disable iff (!rst_n)
        (r_q.st == FHBT_ST_IDLE && r_q.sel == FHBT_SEL_WHOLE &&
         !r_q.dir_wr && !i_cnt_load && level != LVL_FULL)
        |=> (r_q.st == FHBT_ST_IDLE);
    endproperty
    a_whole_rd: assert property (p_whole_rd) // [R9]
        else $error("early read req");

    property p_half_rd;
        @(posedge i_clk) disable iff (!rst_n)
        (r_q.st == FHBT_ST_IDLE && r_q.sel == FHBT_SEL_HALF && !r_q.dir_wr &&
         level >= LVL_HALF && r_q.cnt != '0 && !i_cnt_load)
        |=> (r_q.st == FHBT_ST_BURST);
    endproperty
    a_half_rd: assert property (p_half_rd) // [R5]
        else $error("half read missed");

    property p_req_only_burst;
        @(posedge i_clk) disable iff (!rst_n)
        o_host_req |-> (r_q.st == FHBT_ST_BURST) && (r_q.cnt != '0);
    endproperty
    a_req_only_burst: assert property (p_req_only_burst) // [R14]
        else $error("stray req");

    // a word pushed by the scsi side in the beat cycle hides the pop
    property p_rate;
        @(posedge i_clk) disable iff (!rst_n)
        (o_host_valid && !r_q.dir_wr) |=>
            (level == $past(level) - 1'b1) ||
            ($past(i_scsi_valid) && $past(o_scsi_ready));
    endproperty
    a_rate: assert property (p_rate) // [R10]
        else $error("burst beat lost");

    property p_sel_load;
        @(posedge i_clk) disable iff (!rst_n)
        i_sel_we |=> (o_fifo_level_sel ==
                      {$past(i_host_bus_status_reg[FHBT_SEL_HI_POS]),
                       $past(i_host_bus_status_reg[FHBT_SEL_LO_POS])});
    endproperty
    a_sel_load: assert property (p_sel_load) // [R1]
        else $error("sel not loaded");

    property p_eager_wr;
        @(posedge i_clk) disable iff (!rst_n)
        (r_q.st == FHBT_ST_IDLE && r_q.sel == FHBT_SEL_EAGER && r_q.dir_wr &&
         level != LVL_FULL && r_q.cnt != '0 && !i_cnt_load)
        |=> (r_q.st == FHBT_ST_BURST);
    endproperty
    a_eager_wr: assert property (p_eager_wr) // [R2]
        else $error("eager write missed");

    property p_q_wr;
        @(posedge i_clk) disable iff (!rst_n)
        (r_q.st == FHBT_ST_IDLE && r_q.sel == FHBT_SEL_QUARTER &&
         r_q.dir_wr && !i_cnt_load && level > LVL_1Q)
        |=> (r_q.st == FHBT_ST_IDLE);
    endproperty
    a_q_wr: assert property (p_q_wr) // [R6]
        else $error("quarter write early");

    c_wr_burst: cover property (@(posedge i_clk) disable iff (!rst_n)
        o_host_ready && i_host_valid);
    c_rd_burst: cover property (@(posedge i_clk) disable iff (!rst_n)
        o_host_valid);
    c_cnt_end: cover property (@(posedge i_clk) disable iff (!rst_n)
        burst && r_q.cnt == FHBT_CNT_W'(1) && beat);

endmodule : fhbt_top

// File: tb_top.sv
// tb_top: self-checking bench for fhbt_top with the host master model
// assumes fhbt_pkg, fhbt_fifo and fhbt_top are compiled first
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("unexpected at %0t: got %0h want %0h", \
                     $time, got, exp); \
        end \
    end
module tb_top;
    import fhbt_pkg::*;
    logic clk, rst_n, sel_we, dir_write, cnt_load, scsi_valid, scsi_ready;
    logic [7:0] status;
    logic [3:0] lat;
    logic [FHBT_CNT_W-1:0] cnt_value;
    logic [FHBT_WIDTH-1:0] scsi_data, rd_pat, wr_exp;
    logic host_req, host_gnt, hv_in, host_ready, hv_out, sr_out, sv_out;
    logic cnt_zero;
    logic [FHBT_WIDTH-1:0] hd_in, hd_out, sd_out, last;
    logic [1:0] level_sel;
    logic [15:0] beats, gaps, b0;
    int mismatches, total_checks;

    fhbt_top u_fhbt_top (.i_clk(clk), .i_rst_n(rst_n),
        .i_host_bus_status_reg(status), .i_sel_we(sel_we),
        .i_dir_write(dir_write), .i_cnt_load(cnt_load),
        .i_cnt_value(cnt_value), .o_host_req(host_req),
        .i_host_gnt(host_gnt), .i_host_valid(hv_in), .i_host_data(hd_in),
        .o_host_ready(host_ready), .o_host_valid(hv_out),
        .o_host_data(hd_out), .i_scsi_valid(scsi_valid),
        .i_scsi_data(scsi_data), .o_scsi_ready(sr_out),
        .o_scsi_valid(sv_out), .o_scsi_data(sd_out),
        .i_scsi_ready(scsi_ready), .o_fifo_level_sel(level_sel),
        .o_cnt_zero(cnt_zero));
    fhbt_host_model u_fhbt_host_model (.i_clk(clk), .i_rst_n(rst_n),
        .i_req(host_req), .i_write(dir_write), .i_lat(lat),
        .i_ready(host_ready), .i_valid(hv_out), .i_data(hd_out),
        .o_gnt(host_gnt), .o_valid(hv_in), .o_data(hd_in),
        .o_beats(beats), .o_gaps(gaps), .o_last(last));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic set_sel(input logic [1:0] s);
        status = {s, 6'h15};
        sel_we = 1'b1;
        cyc(1);
        sel_we = 1'b0;
        `CHK(level_sel, s)
    endtask : set_sel

    task automatic load(input logic d, input int n);
        dir_write = d;
        cnt_value = 24'(n);
        cnt_load = 1'b1;
        cyc(1);
        cnt_load = 1'b0;
    endtask : load

    task automatic push(input int n);
        int k;
        for (int i = 0; i < n; i++)
        begin
            scsi_valid = 1'b1;
            scsi_data = rd_pat;
            k = 0;
            while (!sr_out && k < 50)
            begin
                cyc(1);
                k++;
            end
            `CHK(sr_out, 1'b1)
            cyc(1);
            rd_pat++;
        end
        scsi_valid = 1'b0;
    endtask : push

    task automatic pop(input int n);
        int k;
        if (n > 0)
        begin
            scsi_ready = 1'b1;
        end
        for (int i = 0; i < n; i++)
        begin
            k = 0;
            while (!sv_out && k < 50)
            begin
                cyc(1);
                k++;
            end
            `CHK(sv_out, 1'b1)
            `CHK(sd_out, wr_exp)
            cyc(1);
            wr_exp++;
        end
        scsi_ready = 1'b0;
    endtask : pop

    task automatic wait_req(input logic v, input int max);
        int k;
        k = 0;
        while (host_req !== v && k < max)
        begin
            cyc(1);
            k++;
        end
        `CHK(host_req, v)
    endtask : wait_req

    task automatic t_read_thresh;
        int t;
        lat = 4'h0;
        for (int s = 0; s < 4; s++)
        begin
            t = (s == 0) ? 1 : (s == 1) ? FHBT_DEPTH / 2 :
                (s == 2) ? FHBT_DEPTH * 3 / 4 : FHBT_DEPTH;
            set_sel(2'(s));
            load(1'b0, 24);
            push(t - 1);
            cyc(3);
            `CHK(host_req, 1'b0)
            push(1);
            wait_req(1'b1, 3);
            b0 = beats;
            wait_req(1'b0, 40);
            `CHK(beats - b0, 16'(t))
            `CHK(hv_out, 1'b0)
            `CHK(last, rd_pat - 1)
        end
    endtask : t_read_thresh

    task automatic t_write_thresh;
        int l;
        lat = 4'h3;
        set_sel(2'h0);
        load(1'b1, 80);
        wait_req(1'b1, 3);
        b0 = beats;
        wait_req(1'b0, 60);
        `CHK(beats - b0, 16'(FHBT_DEPTH))
        `CHK(host_ready, 1'b0)
        for (int s = 0; s < 4; s++)
        begin
            l = (s == 0) ? FHBT_DEPTH - 1 : (s == 1) ? FHBT_DEPTH / 2 :
                (s == 2) ? FHBT_DEPTH / 4 : 0;
            set_sel(2'(s));
            pop(FHBT_DEPTH - 1 - l);
            cyc(3);
            `CHK(host_req, 1'b0)
            pop(1);
            wait_req(1'b1, 3);
            b0 = beats;
            wait_req(1'b0, 60);
            `CHK(beats - b0, 16'(FHBT_DEPTH - l))
        end
        `CHK(gaps, 16'h0000)
        load(1'b1, 0);
        pop(FHBT_DEPTH);
        cyc(3);
        `CHK(host_req, 1'b0)
    endtask : t_write_thresh

    task automatic t_count_end;
        lat = 4'h0;
        set_sel(2'h0);
        load(1'b0, 3);
        b0 = beats;
        push(5);
        cyc(6);
        `CHK(beats - b0, 16'h0003)
        `CHK(cnt_zero, 1'b1)
        `CHK(host_req, 1'b0)
        `CHK(hv_out, 1'b0)
        load(1'b0, 2);
        cyc(8);
        `CHK(beats - b0, 16'h0005)
        `CHK(last, rd_pat - 1)
    endtask : t_count_end

    task automatic t_reset;
        set_sel(2'h2);
        rst_n = 1'b0;
        cyc(1);
        `CHK(level_sel, 2'h0)
        `CHK(host_req, 1'b0)
        rst_n = 1'b1;
        cyc(3);
    endtask : t_reset

    task automatic print_verdict;
        if (mismatches == 0 && total_checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial
    begin
        rst_n = 1'b0;
        {sel_we, dir_write, cnt_load, scsi_valid, scsi_ready} = 5'h00;
        status = 8'h00;
        lat = 4'h0;
        cnt_value = 24'h00_0000;
        scsi_data = 32'h0000_0000;
        rd_pat = 32'h2000_0000;
        wr_exp = 32'h1000_0000;
        cyc(10);
        rst_n = 1'b1;
        cyc(3);
        `CHK(level_sel, FHBT_SEL_RST)
        // firmware defaults 1,1 and 1,0 and the later 0,0 all used
        t_read_thresh();
        t_write_thresh();
        t_count_end();
        t_reset();
        print_verdict();
    end

    initial
    begin
        #80000;
        mismatches++;
        print_verdict();
    end
endmodule : tb_top
